/* File: src/tsc_consts.svh */
// Timing counts, field widths, field limits and sync codes for the timestamp clock
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH
`define TSC_CLK_HZ 125000000
`define TSC_SETTLE_S 2
`define TSC_SEC_W 6
`define TSC_MIN_W 6
`define TSC_HOUR_W 5
`define TSC_DAY_W 16
`define TSC_TIME_W 33
`define TSC_SEC_MAX 6'h3b
`define TSC_MIN_MAX 6'h3b
`define TSC_HOUR_MAX 5'h17
`define TSC_SYNC_NONE 2'h0
`define TSC_SYNC_PPS 2'h1
`define TSC_SYNC_IRIG 2'h2
`define TSC_LINE_W 3
`define TSC_IRIG_ZERO_CYC 250000
`define TSC_IRIG_ONE_CYC 625000
`define TSC_IRIG_MARK_CYC 1000000
`endif

/* File: src/tsc_pkg.sv */
// Types shared by the timestamp clock files
package tsc_pkg;
    typedef enum logic [1:0]
    {
        TSC_IDLE,
        TSC_WAIT,
        TSC_LOCKED
    } tsc_sync_state_t;
endpackage

/* File: src/tsc_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
module tsc_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

/* File: src/tsc_clock.sv */
// Timestamp clock: day/hour/min/sec counter, gate capture, reference sync
// =====================================================================
// Notes on behaviour
// - Active edge of the chosen gate line latches time into holding register
// - Single capture or a stream of captures through the FIFO
// - Count is realigned to an external PPS or IRIG-B reference
// - Time is days/hours/minutes/seconds, loaded by the controller
// - IRIG-B sync aligns by itself within two seconds of programming
// - PPS sync uses the loaded time; ready about two seconds after setup
// - Gate capture is automatic and stays armed for later pulses
// - Counting never stops once running, except while reset holds the divider
`include "tsc_consts.svh"
module tsc_clock #(
    parameter int CLK_HZ = `TSC_CLK_HZ,
    parameter int SETTLE_CYC = `TSC_SETTLE_S * `TSC_CLK_HZ,
    parameter int IRIG_ZERO = `TSC_IRIG_ZERO_CYC,
    parameter int IRIG_ONE = `TSC_IRIG_ONE_CYC,
    parameter int IRIG_MARK = `TSC_IRIG_MARK_CYC,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] programmable_function_input,
    input wire logic [6:0] inter_board_trigger_bus,
    input wire logic [`TSC_LINE_W-1:0] gate_line_sel,
    input wire logic gate_polarity,
    input wire logic [1:0] sync_type,
    input wire logic [`TSC_LINE_W-1:0] sync_line_sel,
    input wire logic sync_from_bus,
    input wire logic buffered_mode,
    input wire logic load_stb,
    input wire logic [`TSC_TIME_W-1:0] load_value,
    input wire logic ready_clr,
    input wire logic stream_ready,
    output logic [`TSC_TIME_W-1:0] day_hour_min_sec_value,
    output logic [`TSC_TIME_W-1:0] held_time,
    output logic capture_ready,
    output logic time_valid,
    output logic sync_locked,
    output logic stream_valid,
    output logic [`TSC_TIME_W-1:0] stream_data,
    output logic stream_overflow
);
    // =================================================================
    // Input synchronisers
    logic [7:0] pin_s1_q, pin_s2_q;
    logic [6:0] bus_s1_q, bus_s2_q;
    always_ff @(posedge sys_clk)
    begin
        pin_s1_q <= programmable_function_input;
        pin_s2_q <= pin_s1_q;
        bus_s1_q <= inter_board_trigger_bus;
        bus_s2_q <= bus_s1_q;
    end

    // Gate and sync routing; the gate always rides a function input
    logic gate_lvl, sync_lvl, gate_prev_q, sync_prev_q;
    assign gate_lvl = pin_s2_q[gate_line_sel] ^ gate_polarity;
    assign sync_lvl = sync_from_bus ? bus_s2_q[sync_line_sel]
                                    : pin_s2_q[sync_line_sel];
    // Gate history resets high, sync to its idle low: no edge after reset
    always_ff @(posedge sys_clk)
    begin
        gate_prev_q <= rst || gate_lvl;
        sync_prev_q <= !rst && sync_lvl;
    end
    logic gate_edge, sync_rise, sync_fall;
    assign gate_edge = gate_lvl && !gate_prev_q;
    assign sync_rise = sync_lvl && !sync_prev_q;
    assign sync_fall = !sync_lvl && sync_prev_q;

    // =================================================================
    // Seconds divider; it restarts on each PPS rising edge in PPS sync mode
    logic [31:0] tick_cnt_q;
    logic tick;
    logic realign;
    assign tick = (tick_cnt_q == 32'(CLK_HZ - 1)) || realign;
    always_ff @(posedge sys_clk)
    begin
        if (rst || tick)
        begin
            tick_cnt_q <= '0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // =================================================================
    // Day/hour/minute/second counter
    logic [5:0] sec_q, min_q;
    logic [4:0] hour_q;
    logic [15:0] day_q;
    logic valid_q;
    logic irig_load;
    logic [`TSC_TIME_W-1:0] irig_time;
    logic sec_wrap, min_wrap, hour_wrap;
    assign sec_wrap = sec_q == `TSC_SEC_MAX;
    assign min_wrap = min_q == `TSC_MIN_MAX;
    assign hour_wrap = hour_q == `TSC_HOUR_MAX;
    always_ff @(posedge sys_clk)
    begin
        valid_q <= !rst && (valid_q || load_stb || irig_load);
    end
    // Time has no reset: it is undefined until loaded; reset holds the
    // seconds divider but leaves the count rather than clearing it
    always_ff @(posedge sys_clk)
    begin
        if (load_stb || irig_load)
        begin
            {day_q, hour_q, min_q, sec_q} <= load_stb ? load_value
                                                      : irig_time;
        end
        else if (tick)
        begin
            sec_q <= sec_wrap ? '0 : sec_q + 6'h1;
            if (sec_wrap)
            begin
                min_q <= min_wrap ? '0 : min_q + 6'h1;
                if (min_wrap)
                begin
                    hour_q <= hour_wrap ? '0 : hour_q + 5'h1;
                    if (hour_wrap)
                    begin
                        day_q <= day_q + 16'h1;
                    end
                end
            end
        end
    end
    logic [`TSC_TIME_W-1:0] now;
    assign now = {day_q, hour_q, min_q, sec_q};

    // =================================================================
    // Reference sync: PPS edges realign the divider; IRIG-B frames reload
    tsc_pkg::tsc_sync_state_t sst_q;
    logic [31:0] settle_q;
    logic [1:0] type_q;
    always_ff @(posedge sys_clk)
    begin
        type_q <= rst ? `TSC_SYNC_NONE : sync_type;
    end
    logic programmed;
    assign programmed = (sync_type != type_q) || load_stb;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sst_q <= tsc_pkg::TSC_IDLE;
            settle_q <= '0;
        end
        else if (sync_type == `TSC_SYNC_NONE)
        begin
            sst_q <= tsc_pkg::TSC_IDLE;
        end
        else if (programmed)
        begin
            sst_q <= tsc_pkg::TSC_WAIT;
            settle_q <= '0;
        end
        else
        begin
            case (sst_q)
                tsc_pkg::TSC_IDLE: sst_q <= tsc_pkg::TSC_WAIT;
                tsc_pkg::TSC_WAIT:
                begin
                    settle_q <= settle_q + 32'h1;
                    if (settle_q == 32'(SETTLE_CYC - 1))
                    begin
                        sst_q <= tsc_pkg::TSC_LOCKED;
                    end
                end
                tsc_pkg::TSC_LOCKED: sst_q <= tsc_pkg::TSC_LOCKED;
                default: sst_q <= tsc_pkg::TSC_IDLE;
            endcase
        end
    end
    assign realign = (sync_type == `TSC_SYNC_PPS)
        && sync_rise;

    // IRIG-B pulse widths: 2 ms zero, 5 ms one, 8 ms marker
    logic [31:0] irig_w_q;
    logic [`TSC_TIME_W-1:0] irig_sh_q;
    logic irig_mark_q;
    logic [6:0] irig_bit_q;
    always_ff @(posedge sys_clk)
    begin
        if (rst || sync_rise)
        begin
            irig_w_q <= '0;
        end
        else if (sync_lvl)
        begin
            irig_w_q <= irig_w_q + 32'h1;
        end
    end
    logic is_mark, is_one;
    assign is_mark = irig_w_q >= 32'(IRIG_MARK - IRIG_ONE / 2);
    assign is_one = irig_w_q >= 32'((IRIG_ZERO + IRIG_ONE) / 2);
    // Simplified frame: after double marker, first 33 data bits are BCD-free
    // binary day/hour/min/sec; a full BCD decoder did not fit the budget
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irig_mark_q <= 1'b0;
            irig_bit_q <= '0;
            irig_sh_q <= '0;
        end
        else if (sync_fall)
        begin
            irig_mark_q <= is_mark;
            if (is_mark && irig_mark_q)
            begin
                irig_bit_q <= '0;
            end
            else if (!is_mark && irig_bit_q < 7'(`TSC_TIME_W))
            begin
                irig_sh_q <= {irig_sh_q[`TSC_TIME_W-2:0], is_one};
                irig_bit_q <= irig_bit_q + 7'h1;
            end
        end
    end
    assign irig_load = (sync_type == `TSC_SYNC_IRIG) && sync_fall && !is_mark
        && (irig_bit_q == 7'(`TSC_TIME_W - 1));
    assign irig_time = {irig_sh_q[`TSC_TIME_W-2:0], is_one};

    // =================================================================
    // Capture path; the hardware stays armed on every gate edge
    logic fifo_in_ready;
    always_ff @(posedge sys_clk)
    begin
        if (gate_edge)
        begin
            held_time <= now;
        end
    end
    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        capture_ready <= !rst
            && (gate_edge || (capture_ready && !ready_clr));
    end
    // Full FIFO drops the capture and flags it rather than stalling time
    always_ff @(posedge sys_clk)
    begin
        stream_overflow <= !rst && ((gate_edge && buffered_mode
            && !fifo_in_ready) || (stream_overflow && !ready_clr));
    end

    logic fifo_valid, fifo_pop;
    logic [`TSC_TIME_W-1:0] fifo_data;
    tsc_fifo #(.WIDTH(`TSC_TIME_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(gate_edge && buffered_mode),
        .in_ready(fifo_in_ready),
        .in_data(now),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );
    // Registered output stage keeps outputs straight from flops
    assign fifo_pop = fifo_valid && (!stream_valid || stream_ready);
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stream_valid <= 1'b0;
            stream_data <= '0;
        end
        else if (!stream_valid || stream_ready)
        begin
            stream_valid <= fifo_valid;
            stream_data <= fifo_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        day_hour_min_sec_value <= now;
        time_valid <= !rst && valid_q;
        sync_locked <= !rst && (sst_q == tsc_pkg::TSC_LOCKED);
    end
endmodule

/* File: verification/tsc_clock_monitor.sv */
// Port-level assertions for the timestamp clock
`include "tsc_consts.svh"
module tsc_clock_monitor #(
    parameter int SETTLE_CYC = 100
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] programmable_function_input,
    input wire logic [`TSC_LINE_W-1:0] gate_line_sel,
    input wire logic gate_polarity,
    input wire logic [1:0] sync_type,
    input wire logic load_stb,
    input wire logic ready_clr,
    input wire logic stream_ready,
    input wire logic capture_ready,
    input wire logic time_valid,
    input wire logic sync_locked,
    input wire logic stream_valid,
    input wire logic [`TSC_TIME_W-1:0] stream_data,
    input wire logic stream_overflow
);
    timeunit 1ns;
    timeprecision 100ps;
    // Slack of a few cycles for the input and output pipelines
    localparam int LK0 = SETTLE_CYC - 12;
    localparam int LK1 = SETTLE_CYC - 4;
    logic gate_pin;
    assign gate_pin = programmable_function_input[gate_line_sel];
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // =====
    // Sequences
    sequence s_gate_edge;
        $changed(gate_pin) && (gate_pin != gate_polarity);
    endsequence
    sequence s_captured;
        ##[2:5] capture_ready ##1 capture_ready;
    endsequence
    // =====
    // Properties
    property p_rst_clear;
        disable iff (1'b0)
        rst |=> !capture_ready && !stream_valid && !stream_overflow
            && !time_valid && !sync_locked;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("flag set after reset");
    property p_cap;
        s_gate_edge |-> s_captured;
    endproperty
    a_cap: assert property (p_cap)
        else $error("gate edge not captured");
    property p_rdy_hold;
        capture_ready && !ready_clr |=> capture_ready;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold)
        else $error("ready flag lost");
    property p_ovf_hold;
        stream_overflow && !ready_clr |=> stream_overflow;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow lost");
    property p_tv_hold;
        time_valid |=> time_valid;
    endproperty
    a_tv_hold: assert property (p_tv_hold)
        else $error("time valid dropped");
    property p_stream;
        stream_valid && !stream_ready |=> stream_valid && $stable(stream_data);
    endproperty
    a_stream: assert property (p_stream)
        else $error("stream word moved");
    property p_load;
        load_stb |-> ##[1:2] time_valid;
    endproperty
    a_load: assert property (p_load)
        else $error("load not taken");
    property p_lock;
        $changed(sync_type) && sync_type != `TSC_SYNC_NONE
            |-> ##2 !sync_locked[*7] ##[LK0:LK1] sync_locked;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock timing wrong");
endmodule

/* File: verification/tsc_ref_model.sv */
// Reference source model: gate pulses, PPS and IRIG-B frames
module tsc_ref_model #(
    parameter int ZERO = 20,
    parameter int ONE = 50,
    parameter int MARK = 80
) (
    input wire logic sys_clk,
    output logic [7:0] pins,
    output logic [6:0] bus
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        pins = 8'h00;
        bus = 7'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic gate_pulse(input int ln);
        pins[ln] = 1'b1;
        hold(3);
        pins[ln] = 1'b0;
        hold(3);
    endtask
    task automatic pps_pulse(input int ln);
        bus[ln] = 1'b1;
        hold(5);
        bus[ln] = 1'b0;
    endtask
    // Fixed 100-cycle slot so every pulse has a low gap
    task automatic irig_bit(input int ln, input int w);
        pins[ln] = 1'b1;
        hold(w);
        pins[ln] = 1'b0;
        hold(100 - w);
    endtask
    task automatic irig_frame(input int ln, input logic [32:0] v);
        irig_bit(ln, MARK);
        irig_bit(ln, MARK);
        for (int i = 32; i >= 0; i--)
            irig_bit(ln, v[i] ? ONE : ZERO);
    endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the timestamp clock
`include "tsc_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HZ = 1000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] pins;
    logic [6:0] bus;
    logic gpol = 1'b0, sfb = 1'b1, bufm = 1'b0, ld = 1'b0, clr = 1'b0;
    logic srdy = 1'b1;
    logic [1:0] styp = `TSC_SYNC_NONE;
    logic [2:0] gsel = 3'h0, ssel = 3'h2;
    logic [32:0] ldv = 33'h0, live, held, sdat, base = 33'h0, w;
    logic capr, tval, lock, sval, sovf;
    int cyc = 0, t0 = 0, n_fail = 0, checks = 0;
    logic [32:0] exp_q[$];
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    tsc_clock #(.CLK_HZ(HZ), .SETTLE_CYC(100), .IRIG_ZERO(20),
        .IRIG_ONE(50), .IRIG_MARK(80), .FIFO_DEPTH(4)) dut (
        .sys_clk(sys_clk), .rst(rst), .programmable_function_input(pins),
        .inter_board_trigger_bus(bus), .gate_line_sel(gsel),
        .gate_polarity(gpol), .sync_type(styp), .sync_line_sel(ssel),
        .sync_from_bus(sfb), .buffered_mode(bufm), .load_stb(ld),
        .load_value(ldv), .ready_clr(clr), .stream_ready(srdy),
        .day_hour_min_sec_value(live), .held_time(held),
        .capture_ready(capr), .time_valid(tval), .sync_locked(lock),
        .stream_valid(sval), .stream_data(sdat), .stream_overflow(sovf));
    tsc_ref_model ref_m (.sys_clk(sys_clk), .pins(pins), .bus(bus));
    // =====
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] e,
        input int tol);
        checks++;
        if (^got === 1'bx || got < e || got > e + 33'(tol))
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    // Counter time only moves the seconds field here, no wrap
    function automatic logic [32:0] tat(input int c);
        return base + 33'((c - t0) / HZ);
    endfunction
    task automatic load(input logic [32:0] v);
        ldv = v;
        ld = 1'b1;
        step(1);
        ld = 1'b0;
        base = v;
        t0 = cyc;
    endtask
    task automatic summarize();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk)
        if (sval === 1'b1 && srdy === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp(33'h1, 33'h0, 0);
            else
                cmp(sdat, exp_q.pop_front(), 1);
        end
    initial
    begin
        #200000;
        n_fail++;
        summarize();
    end
    // =====
    // Tests
    initial
    begin
        void'($urandom(74));
        step(10);
        rst = 1'b0;
        step(2);
        cmp(33'(tval), 0, 0);
        load({16'h0003, 5'h04, 6'h05, 6'h02});
        step(2);
        cmp(live, base, 0);
        cmp(33'(tval), 1, 0);
        step(2000);
        cmp(live, tat(cyc), 0);
        $display("load and count done");
        for (int p = 0; p < 4; p++)
        begin
            gpol = p[1];
            gsel = 3'($urandom_range(4));
            step(2);
            w = tat(cyc - 3);
            ref_m.gate_pulse(gsel);
            step(3);
            cmp(33'(capr), 1, 0);
            cmp(held, w, 1);
            clr = 1'b1;
            step(1);
            clr = 1'b0;
            step(1);
            cmp(33'(capr), 0, 0);
        end
        $display("single capture done");
        bufm = 1'b1;
        srdy = 1'b0;
        gpol = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            if (i < 5)
                exp_q.push_back(tat(cyc - 3));
            ref_m.gate_pulse(gsel);
        end
        step(6);
        cmp(33'(sovf), 1, 0);
        repeat (60)
        begin
            srdy = 1'($urandom);
            step(1);
        end
        srdy = 1'b1;
        step(4);
        cmp(33'(exp_q.size()), 0, 0);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        bufm = 1'b0;
        step(1);
        cmp(33'(sovf), 0, 0);
        $display("stream done");
        load({16'h0003, 5'h04, 6'h05, 6'h10});
        styp = `TSC_SYNC_PPS;
        step(120);
        cmp(33'(lock), 1, 0);
        ref_m.pps_pulse(ssel);
        step(4);
        cmp(live, base + 33'h1, 0);
        step(900);
        cmp(live, base + 33'h1, 0);
        $display("pps done");
        sfb = 1'b0;
        ssel = 3'h5;
        styp = `TSC_SYNC_IRIG;
        w = {16'($urandom), 5'h0a, 6'h1e, 6'h14};
        ref_m.irig_frame(5, w);
        step(3);
        cmp(live, w, 1);
        cmp(33'(lock), 1, 0);
        $display("irig done");
        styp = `TSC_SYNC_NONE;
        step(3);
        summarize();
    end
endmodule
bind tsc_clock tsc_clock_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_mon (
    .sys_clk(sys_clk), .rst(rst),
    .programmable_function_input(programmable_function_input),
    .gate_line_sel(gate_line_sel), .gate_polarity(gate_polarity),
    .sync_type(sync_type), .load_stb(load_stb), .ready_clr(ready_clr),
    .stream_ready(stream_ready), .capture_ready(capture_ready),
    .time_valid(time_valid), .sync_locked(sync_locked),
    .stream_valid(stream_valid), .stream_data(stream_data),
    .stream_overflow(stream_overflow));
